//--- rtl/scfg_defines.svh
// register offsets, field positions, reset values and counts of the strap configuration block
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH
`define SCFG_OFF_DEVID 8'h00
`define SCFG_OFF_RESET 8'h01
`define SCFG_OFF_BRCTL 8'h4f
`define SCFG_OFF_BRCFG 8'h54
`define SCFG_OFF_LINK1 8'h5b
`define SCFG_BIT_ADDR_SEL 0
`define SCFG_BIT_AUTO_SLEEP 7
`define SCFG_BIT_FRONT_RST 4
`define SCFG_BIT_FULL_RST 1
`define SCFG_BIT_CORE_RST 0
`define SCFG_BIT_DISP_ID 0
`define SCFG_BIT_AUX_AUDIO 1
`define SCFG_BIT_REM_ID 5
`define SCFG_BIT_OVERRIDE 7
`define SCFG_BIT_CABLE 7
`define SCFG_LVL_MSB 2
`define SCFG_LVL_MID 1
`define SCFG_LVL_LSB 0
`define SCFG_ADDR_BASE 7'h0c
`define SCFG_REG_RESET 8'h00
`define SCFG_ADDR_RESET 7'h00
`define SCFG_STRAP_SETTLE 2'h3
`define SCFG_NEW_RX_MAX_MHZ 8'h60
`define SCFG_OLD_RX_LIMIT_MHZ 8'h55
`define SCFG_BIT_LAST 4'h7
`define SCFG_BIT_ACK 4'h8
`endif

//--- rtl/scfg_pkg.sv
// types shared by the strap configuration block
package scfg_pkg;
  typedef logic [7:0] scfg_byte_t;
  typedef logic [2:0] scfg_level_t;
  typedef logic [6:0] scfg_addr_t;
  typedef enum logic [2:0] {
    SCFG_IDLE,
    SCFG_ADDR,
    SCFG_ADDR_ACK,
    SCFG_WR_BYTE,
    SCFG_WR_ACK,
    SCFG_RD_BYTE,
    SCFG_RD_ACK
  } scfg_slave_state_e;
endpackage

//--- rtl/scfg_bus_slave.sv
// two-wire bus slave running on the bus sampling clock
`timescale 1ns/1ps
`include "scfg_defines.svh"
module scfg_bus_slave (
  input wire logic link_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_tgl_in,
  input wire scfg_pkg::scfg_addr_t dev_addr_in,
  input wire logic ack_tgl_in,
  input wire scfg_pkg::scfg_byte_t rsp_data_in,
  output logic req_tgl_out,
  output logic req_wr_out,
  output scfg_pkg::scfg_byte_t req_off_out,
  output scfg_pkg::scfg_byte_t req_data_out,
  output logic sda_oe_out
);
  import scfg_pkg::*;
  logic rst_m, rst_s, scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic at_m, at_s, at_d, ak_m, ak_s, ak_d;
  logic scl_rise, scl_fall, start_evt, stop_evt, rw_reg, first_reg;
  logic [3:0] cnt_reg;
  scfg_byte_t shift_reg, ptr_reg, rd_buf_reg;
  scfg_addr_t own_addr_reg;
  scfg_slave_state_e state_reg;

  // pins and crossing toggles pass two flops before any logic looks at them
  always_ff @(posedge link_clk_in) begin
    {rst_m, rst_s} <= {rst_n_in, rst_m};
    {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
    {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    {at_m, at_s, at_d} <= {addr_tgl_in, at_m, at_s};
    {ak_m, ak_s, ak_d} <= {ack_tgl_in, ak_m, ak_s};
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_evt = scl_s && scl_d && sda_d && !sda_s;
  assign stop_evt = scl_s && scl_d && !sda_d && sda_s;

  // address word is stable once its toggle has crossed
  always_ff @(posedge link_clk_in) begin
    if (!rst_s) begin
      own_addr_reg <= `SCFG_ADDR_RESET;
      rd_buf_reg <= `SCFG_REG_RESET;
    end else begin
      if (at_s != at_d) begin
        own_addr_reg <= dev_addr_in;
      end
      if (ak_s != ak_d) begin
        rd_buf_reg <= rsp_data_in;
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!rst_s) begin
      state_reg <= SCFG_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= `SCFG_REG_RESET;
      ptr_reg <= `SCFG_REG_RESET;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      sda_oe_out <= 1'b0;
      req_tgl_out <= 1'b0;
      req_wr_out <= 1'b0;
      req_off_out <= `SCFG_REG_RESET;
      req_data_out <= `SCFG_REG_RESET;
    end else if (start_evt) begin
      state_reg <= SCFG_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_evt) begin
      state_reg <= SCFG_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state_reg)
        SCFG_ADDR, SCFG_WR_BYTE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == `SCFG_BIT_ACK) begin
            if (state_reg == SCFG_WR_BYTE) begin
              sda_oe_out <= 1'b1;
              state_reg <= SCFG_WR_ACK;
              first_reg <= 1'b0;
              if (first_reg) begin
                ptr_reg <= shift_reg;
              end else begin
                req_tgl_out <= !req_tgl_out;
                req_wr_out <= 1'b1;
                req_off_out <= ptr_reg;
                req_data_out <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
            end else if (shift_reg[7:1] == own_addr_reg) begin
              sda_oe_out <= 1'b1;
              rw_reg <= shift_reg[0];
              state_reg <= SCFG_ADDR_ACK;
              if (shift_reg[0]) begin
                req_tgl_out <= !req_tgl_out;
                req_wr_out <= 1'b0;
                req_off_out <= ptr_reg;
              end
            end else begin
              state_reg <= SCFG_IDLE;
            end
          end
        end
        SCFG_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            if (rw_reg) begin
              // next byte is prefetched while this one shifts out
              shift_reg <= rd_buf_reg;
              sda_oe_out <= !rd_buf_reg[7];
              state_reg <= SCFG_RD_BYTE;
              ptr_reg <= ptr_reg + 8'h01;
              req_tgl_out <= !req_tgl_out;
              req_wr_out <= 1'b0;
              req_off_out <= ptr_reg + 8'h01;
            end else begin
              sda_oe_out <= 1'b0;
              first_reg <= 1'b1;
              state_reg <= SCFG_WR_BYTE;
            end
          end
        end
        SCFG_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            cnt_reg <= 4'h0;
            state_reg <= SCFG_WR_BYTE;
          end
        end
        SCFG_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt_reg == `SCFG_BIT_LAST) begin
              sda_oe_out <= 1'b0;
              state_reg <= SCFG_RD_ACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_out <= !shift_reg[6];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        SCFG_RD_ACK: begin
          if (scl_rise) begin
            state_reg <= sda_s ? SCFG_IDLE : SCFG_ADDR_ACK;
          end
        end
        default: begin
          state_reg <= SCFG_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge link_clk_in); endclocking
  default disable iff (!rst_s);
  a_stop_idle: assert property (stop_evt && !start_evt |=> state_reg == SCFG_IDLE)
    else $error("stop did not end transaction");
  a_idle_quiet: assert property (state_reg == SCFG_IDLE |-> !sda_oe_out)
    else $error("sda driven outside a transaction");
  a_addr_ack: assert property (state_reg == SCFG_ADDR && scl_fall && cnt_reg == 4'h8 &&
    !start_evt && !stop_evt |=> sda_oe_out == ($past(shift_reg[7:1]) == own_addr_reg))
    else $error("address acknowledge wrong");
  a_wr_ack: assert property (state_reg == SCFG_WR_BYTE && scl_fall && cnt_reg == 4'h8 &&
    !start_evt && !stop_evt |=> sda_oe_out && state_reg == SCFG_WR_ACK)
    else $error("write byte not acknowledged");
  a_rd_nack: assert property (state_reg == SCFG_RD_ACK && scl_rise && sda_s &&
    !start_evt && !stop_evt |=> state_reg == SCFG_IDLE ##1 !sda_oe_out)
    else $error("master nack did not end read");
  c_read: cover property (state_reg == SCFG_RD_ACK && scl_rise && !sda_s);
  c_write: cover property (state_reg == SCFG_WR_ACK && !first_reg);
  c_nomatch: cover property (state_reg == SCFG_ADDR ##1 state_reg == SCFG_IDLE);
endmodule

//--- rtl/scfg_strap_config.sv
// strap decode, configuration registers and bus slave of the bridge front end
// Summary of operation
// - second strap level gives override, cable, id-load bits
// - strap results readable and writable in registers
// - aux audio, id-load, override latched into config register
// - single link up to 96 MHz, newer receivers
// - older receivers only below 85 MHz
// - shared-bus slave, address picked by strap
// - address is 0x0c plus twice level index
// - scl input only, sda driven low only
// - stop ends current transaction
// - transactions framed by start and stop
// - acknowledge own address, release on mismatch
// - acknowledge every written data byte
// - straps sampled into registers at power-up
// - address register overrides strap when enabled
`timescale 1ns/1ps
`include "scfg_defines.svh"
module scfg_strap_config #(
  parameter int ADDR_BITS = 7
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire scfg_pkg::scfg_level_t config_strap_a_in,
  input wire scfg_pkg::scfg_level_t config_strap_b_in,
  input wire scfg_pkg::scfg_level_t address_select_strap_in,
  input wire scfg_pkg::scfg_byte_t pixel_freq_mhz_in,
  input wire logic newer_receiver_in,
  output logic display_id_source_bit_out,
  output logic auto_sleep_out,
  output logic aux_audio_out,
  output logic outside_control_bit_out,
  output logic cable_type_bit_out,
  output logic remote_display_id_copy_out,
  output logic single_link_ok_out,
  output logic front_reset_out,
  output logic core_reset_out
);
  import scfg_pkg::*;

  if (ADDR_BITS != 7) begin : g_check
    $error("scfg_strap_config serves only 7-bit slave addresses");
  end

  scfg_level_t strap_a_m, strap_a_s, strap_b_m, strap_b_s, strap_id_m, strap_id_s;
  logic [1:0] settle_reg;
  logic latched_reg, latch_now, full_reset_reg;
  scfg_byte_t reg00_reg, reg4f_reg, reg54_reg, reg5b_reg, rd_mux, rsp_data_reg;
  logic sleep_reg;
  scfg_addr_t strap_addr, dev_addr_next, dev_addr_reg;
  logic addr_tgl_reg, ack_tgl_reg, sda_zero_reg;
  logic req_tgl, req_wr, req_m, req_s, req_d, req_evt, wr_now;
  scfg_byte_t req_off, req_data;
  logic slave_oe;

  // strap pins are static but asynchronous to this clock
  always_ff @(posedge ref_clk_in) begin
    strap_a_m <= config_strap_a_in;
    strap_a_s <= strap_a_m;
    strap_b_m <= config_strap_b_in;
    strap_b_s <= strap_b_m;
    strap_id_m <= address_select_strap_in;
    strap_id_s <= strap_id_m;
  end

  // wait for the synchronisers to fill before latching
  assign latch_now = !latched_reg && settle_reg == `SCFG_STRAP_SETTLE;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || full_reset_reg) begin
      settle_reg <= 2'h0;
      latched_reg <= 1'b0;
    end else if (latch_now) begin
      latched_reg <= 1'b1;
    end else if (!latched_reg) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  assign strap_addr = `SCFG_ADDR_BASE + {3'h0, strap_id_s, 1'b0};

  // crossing of requests from the bus domain
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      req_d <= 1'b0;
    end else begin
      req_m <= req_tgl;
      req_s <= req_m;
      req_d <= req_s;
    end
  end
  assign req_evt = req_s ^ req_d;
  assign wr_now = req_evt && req_wr && latched_reg;

  // configuration registers: power-up strap load, then host writes win
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || full_reset_reg) begin
      reg00_reg <= `SCFG_REG_RESET;
      reg4f_reg <= `SCFG_REG_RESET;
      reg54_reg <= `SCFG_REG_RESET;
      reg5b_reg <= `SCFG_REG_RESET;
      sleep_reg <= 1'b0;
    end else if (latch_now) begin
      reg00_reg[7:1] <= strap_addr;
      reg4f_reg[`SCFG_BIT_DISP_ID] <= strap_a_s[`SCFG_LVL_MSB];
      sleep_reg <= strap_a_s[`SCFG_LVL_MID];
      reg54_reg[`SCFG_BIT_AUX_AUDIO] <= strap_a_s[`SCFG_LVL_LSB];
      reg54_reg[`SCFG_BIT_OVERRIDE] <= strap_b_s[`SCFG_LVL_MSB];
      reg5b_reg[`SCFG_BIT_CABLE] <= strap_b_s[`SCFG_LVL_MID];
      reg54_reg[`SCFG_BIT_REM_ID] <= strap_b_s[`SCFG_LVL_LSB];
    end else if (wr_now) begin
      case (req_off)
        `SCFG_OFF_DEVID: reg00_reg <= req_data;
        `SCFG_OFF_RESET: sleep_reg <= req_data[`SCFG_BIT_AUTO_SLEEP];
        `SCFG_OFF_BRCTL: reg4f_reg <= req_data;
        `SCFG_OFF_BRCFG: reg54_reg <= req_data;
        `SCFG_OFF_LINK1: reg5b_reg <= req_data;
        default: begin
        end
      endcase
    end
  end

  // self-clearing reset bits become one-cycle pulses
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      full_reset_reg <= 1'b0;
      front_reset_out <= 1'b0;
      core_reset_out <= 1'b0;
    end else begin
      full_reset_reg <= wr_now && req_off == `SCFG_OFF_RESET && req_data[`SCFG_BIT_FULL_RST];
      front_reset_out <= wr_now && req_off == `SCFG_OFF_RESET &&
                         req_data[`SCFG_BIT_FRONT_RST];
      core_reset_out <= wr_now && req_off == `SCFG_OFF_RESET && req_data[`SCFG_BIT_CORE_RST];
    end
  end

  always_comb begin
    case (req_off)
      `SCFG_OFF_DEVID: rd_mux = reg00_reg;
      `SCFG_OFF_RESET: rd_mux = {sleep_reg, 7'h00};
      `SCFG_OFF_BRCTL: rd_mux = reg4f_reg;
      `SCFG_OFF_BRCFG: rd_mux = reg54_reg;
      `SCFG_OFF_LINK1: rd_mux = reg5b_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // every request gets an answer toggle, reads carry data back
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rsp_data_reg <= `SCFG_REG_RESET;
      ack_tgl_reg <= 1'b0;
    end else if (req_evt) begin
      rsp_data_reg <= rd_mux;
      ack_tgl_reg <= !ack_tgl_reg;
    end
  end

  assign dev_addr_next = reg00_reg[`SCFG_BIT_ADDR_SEL] ? reg00_reg[7:1] : strap_addr;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      dev_addr_reg <= `SCFG_ADDR_RESET;
      addr_tgl_reg <= 1'b0;
    end else if (latched_reg && dev_addr_next != dev_addr_reg) begin
      dev_addr_reg <= dev_addr_next;
      addr_tgl_reg <= !addr_tgl_reg;
    end
  end

  // older receivers need strictly less than their limit
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      single_link_ok_out <= 1'b0;
    end else if (newer_receiver_in) begin
      single_link_ok_out <= pixel_freq_mhz_in <= `SCFG_NEW_RX_MAX_MHZ;
    end else begin
      single_link_ok_out <= pixel_freq_mhz_in < `SCFG_OLD_RX_LIMIT_MHZ;
    end
  end

  // the line is only ever pulled low; pull-ups give the high level
  always_ff @(posedge ref_clk_in) begin
    sda_zero_reg <= 1'b0;
  end
  assign sda_out = sda_zero_reg;
  assign sda_oe_out = slave_oe;

  assign display_id_source_bit_out = reg4f_reg[`SCFG_BIT_DISP_ID];
  assign auto_sleep_out = sleep_reg;
  assign aux_audio_out = reg54_reg[`SCFG_BIT_AUX_AUDIO];
  assign outside_control_bit_out = reg54_reg[`SCFG_BIT_OVERRIDE];
  assign cable_type_bit_out = reg5b_reg[`SCFG_BIT_CABLE];
  assign remote_display_id_copy_out = reg54_reg[`SCFG_BIT_REM_ID];

  scfg_bus_slave u_slave (
    .link_clk_in(link_clk_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .addr_tgl_in(addr_tgl_reg),
    .dev_addr_in(dev_addr_reg),
    .ack_tgl_in(ack_tgl_reg),
    .rsp_data_in(rsp_data_reg),
    .req_tgl_out(req_tgl),
    .req_wr_out(req_wr),
    .req_off_out(req_off),
    .req_data_out(req_data),
    .sda_oe_out(slave_oe)
  );

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_mode_b_decode: assert property (latch_now |=>
    reg54_reg[7] == $past(strap_b_s[2]) && reg5b_reg[7] == $past(strap_b_s[1]))
    else $error("second strap decode wrong");
  a_mode_a_latch: assert property (latch_now |=>
    reg4f_reg[0] == $past(strap_a_s[2]) && sleep_reg == $past(strap_a_s[1]))
    else $error("first strap not latched");
  a_bridge_cfg: assert property (latch_now |=>
    reg54_reg[1] == $past(strap_a_s[0]) && reg54_reg[5] == $past(strap_b_s[0]))
    else $error("bridge configuration strap bits wrong");
  a_new_rx_limit: assert property (newer_receiver_in && pixel_freq_mhz_in == 8'h61
    |=> !single_link_ok_out) else $error("newer receiver limit exceeded");
  a_old_rx_limit: assert property (!newer_receiver_in && pixel_freq_mhz_in == 8'h55
    |=> !single_link_ok_out) else $error("older receiver limit exceeded");
  a_strap_addr: assert property (latch_now |=>
    reg00_reg[7:1] == 7'h0c + {3'h0, $past(strap_id_s), 1'b0}) else $error("strap address wrong");
  a_power_latch: assert property ($rose(latched_reg) |-> $past(settle_reg, 1) == 2'h3)
    else $error("straps latched before settling");
  a_addr_select: assert property (latched_reg && !full_reset_reg |=>
    dev_addr_reg == ($past(reg00_reg[0]) ? $past(reg00_reg[7:1]) : $past(strap_addr)))
    else $error("slave address source wrong");
  a_req_answer: assert property (req_evt |=> ack_tgl_reg != $past(ack_tgl_reg))
    else $error("request not answered");
  a_host_override: assert property (wr_now && req_off == 8'h5b && !full_reset_reg
    |=> reg5b_reg == $past(req_data)) else $error("host write lost");

  // host writes land whole once the straps are in, except register 01, which keeps only its sleep bit
  a_wr_devid: assert property (wr_now && req_off == 8'h00 && !full_reset_reg
    |=> reg00_reg == $past(req_data))
    else $error("address register write lost");
  a_wr_bridge_control: assert property (wr_now && req_off == 8'h4f && !full_reset_reg
    |=> reg4f_reg == $past(req_data))
    else $error("bridge control write lost");
  a_wr_bridge_cfg: assert property (wr_now && req_off == 8'h54 && !full_reset_reg
    |=> reg54_reg == $past(req_data))
    else $error("bridge configuration write lost");
  a_wr_sleep: assert property (wr_now && req_off == 8'h01 && !full_reset_reg
    |=> sleep_reg == $past(req_data[7]))
    else $error("sleep bit write lost");

  // a full register reset wins over strap load and host write alike
  a_full_clear: assert property (full_reset_reg |=>
    reg00_reg == 8'h00 && reg4f_reg == 8'h00 && reg54_reg == 8'h00 && reg5b_reg == 8'h00)
    else $error("full register reset left a value");
  a_full_relatch: assert property (full_reset_reg |=> !latched_reg && !sleep_reg)
    else $error("full register reset did not restart strap load");
  a_hold_unlatched: assert property (!latched_reg && !latch_now && !full_reset_reg
    |=> reg54_reg == $past(reg54_reg) && reg5b_reg == $past(reg5b_reg))
    else $error("register moved before straps latched");
  a_early_write: assert property (req_evt && req_wr && !latched_reg && !latch_now
    && !full_reset_reg |=> reg4f_reg == $past(reg4f_reg))
    else $error("write taken before straps latched");

  // pixel limits, both sides of each bound
  a_new_rx_ok: assert property (newer_receiver_in && pixel_freq_mhz_in <= 8'h60
    |=> single_link_ok_out)
    else $error("newer receiver refused within limit");
  a_new_rx_high: assert property (newer_receiver_in && pixel_freq_mhz_in > 8'h60
    |=> !single_link_ok_out)
    else $error("newer receiver allowed above limit");
  a_old_rx_ok: assert property (!newer_receiver_in && pixel_freq_mhz_in < 8'h55
    |=> single_link_ok_out)
    else $error("older receiver refused below limit");
  a_old_rx_high: assert property (!newer_receiver_in && pixel_freq_mhz_in > 8'h55
    |=> !single_link_ok_out)
    else $error("older receiver allowed above limit");

  // read answers carry the register as it stood when asked
  a_read_sleep: assert property (req_evt && !req_wr && req_off == 8'h01
    |=> rsp_data_reg == {$past(sleep_reg), 7'h00})
    else $error("sleep bit read wrong");
  a_read_cfg: assert property (req_evt && !req_wr && req_off == 8'h54
    |=> rsp_data_reg == $past(reg54_reg))
    else $error("bridge configuration read wrong");
  a_read_link: assert property (req_evt && !req_wr && req_off == 8'h5b
    |=> rsp_data_reg == $past(reg5b_reg))
    else $error("link control read wrong");
  a_strap_range: assert property (latched_reg |-> !strap_addr[0] &&
    strap_addr >= 7'h0c && strap_addr <= 7'h1a)
    else $error("strap address out of range");
  a_sda_low: assert property (sda_out == 1'b0)
    else $error("data line driven high");

  c_latch: cover property (latch_now);
  c_override: cover property (wr_now && req_off == 8'h54);
endmodule

//--- verif/scfg_host_model.sv
// two-wire bus master model standing for the local host controller
`timescale 1ns/1ps
module scfg_host_model #(
  parameter int QTR = 110
) (
  input wire logic ref_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic qtr();
    repeat (QTR) @(negedge ref_clk_in);
  endtask

  // wait up to 4000 cycles for the clock line to read high before timing the high phase
  task automatic scl_rise();
    int n;
    n = 0;
    scl_out = 1'b1;
    while (scl_in !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_in);
      n++;
    end
    qtr();
  endtask

  task automatic start_cond();
    sda_out = 1'b1;
    qtr();
    scl_rise();
    sda_out = 1'b0;
    qtr();
    scl_out = 1'b0;
    qtr();
  endtask

  task automatic stop_cond();
    sda_out = 1'b0;
    qtr();
    scl_rise();
    sda_out = 1'b1;
    qtr();
  endtask

  // data held past the clock fall so the synchronised lines never fake a start or stop
  task automatic bit_xfer(input logic b, output logic got);
    sda_out = b;
    qtr();
    scl_rise();
    got = sda_in;
    scl_out = 1'b0;
    repeat (32) @(negedge ref_clk_in);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], g);
    end
    bit_xfer(1'b1, g);
    ack = ~g;
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, g);
      d[i] = g;
    end
    bit_xfer(~more, g);
  endtask

  task automatic reg_write(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
      output logic [2:0] acks);
    start_cond();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(off, acks[1]);
    send_byte(d, acks[0]);
    stop_cond();
  endtask

  task automatic reg_read(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d,
      output logic [2:0] acks);
    start_cond();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(off, acks[1]);
    start_cond();
    send_byte({a, 1'b1}, acks[0]);
    recv_byte(1'b0, d);
    stop_cond();
  endtask

  // framed=0 clocks an address byte with no start in front of it
  task automatic probe(input logic [6:0] a, input logic framed, output logic ack);
    if (framed) begin
      start_cond();
    end else begin
      scl_out = 1'b0;
      qtr();
    end
    send_byte({a, 1'b0}, ack);
    stop_cond();
  endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the strap configuration front end
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap_a = 3'h0;
  logic [2:0] strap_b = 3'h0;
  logic [2:0] strap_id = 3'h0;
  logic [7:0] pix_mhz = 8'h00;
  logic newer_rx = 1'b0;
  logic host_scl, host_sda, sda_w, dev_sda, dev_oe;
  logic disp_id, auto_sleep, aux_audio, ovr, cable, rem_id, link_ok, front_rst, core_rst;
  int n_fail = 0;
  int cmp_count = 0;
  int n_front = 0;
  int n_core = 0;

  always #2 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // open-drain data line, pull-up wins when nobody pulls low
  assign sda_w = host_sda & ~dev_oe;

  scfg_strap_config scfg_strap_config_i (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .link_clk_in(link_clk),
    .scl_in(host_scl), .sda_in(sda_w), .sda_out(dev_sda), .sda_oe_out(dev_oe),
    .config_strap_a_in(strap_a), .config_strap_b_in(strap_b),
    .address_select_strap_in(strap_id), .pixel_freq_mhz_in(pix_mhz),
    .newer_receiver_in(newer_rx), .display_id_source_bit_out(disp_id),
    .auto_sleep_out(auto_sleep), .aux_audio_out(aux_audio),
    .outside_control_bit_out(ovr), .cable_type_bit_out(cable),
    .remote_display_id_copy_out(rem_id), .single_link_ok_out(link_ok),
    .front_reset_out(front_rst), .core_reset_out(core_rst)
  );

  scfg_host_model scfg_host_model_i (
    .ref_clk_in(ref_clk), .scl_in(host_scl), .sda_in(sda_w),
    .scl_out(host_scl), .sda_out(host_sda)
  );

  always @(negedge ref_clk) begin
    if (front_rst === 1'b1) n_front++;
    if (core_rst === 1'b1) n_core++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // held long enough for the link-side reset copy, then 1.2 us before bus traffic
  task automatic do_reset();
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (60) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (300) @(negedge ref_clk);
  endtask

  task automatic t_pixel();
    logic [9:0] tbl [4] = '{10'h360, 10'h261, 10'h154, 10'h055};
    foreach (tbl[i]) begin
      newer_rx = tbl[i][9];
      pix_mhz = tbl[i][7:0];
      repeat (3) @(negedge ref_clk);
      chk(link_ok, tbl[i][8]);
    end
  endtask

  task automatic t_strap();
    for (int n = 0; n < 8; n++) begin
      strap_b = n[2:0];
      strap_a = 3'h7 - n[2:0];
      do_reset();
      chk({ovr, cable, rem_id}, n[2:0]);
      chk({disp_id, auto_sleep, aux_audio}, 3'h7 - n[2:0]);
    end
  endtask

  task automatic t_addr();
    logic ack;
    for (int n = 0; n < 8; n++) begin
      strap_id = n[2:0];
      do_reset();
      scfg_host_model_i.probe(7'h0c + 7'(2 * n), 1'b1, ack);
      chk(ack, 1'b1);
    end
    scfg_host_model_i.probe(7'h0c, 1'b1, ack);
    chk(ack, 1'b0);
    scfg_host_model_i.probe(7'h1a, 1'b0, ack);
    chk(ack, 1'b0);
    chk(dev_sda, 1'b0);
  endtask

  task automatic t_regs();
    logic [2:0] acks;
    logic [7:0] d;
    scfg_host_model_i.reg_write(7'h1a, 8'h5b, 8'h85, acks);
    chk(acks, 3'h7);
    chk(cable, 1'b1);
    scfg_host_model_i.reg_read(7'h1a, 8'h5b, d, acks);
    chk(d, 8'h85);
    n_front = 0;
    n_core = 0;
    scfg_host_model_i.reg_write(7'h1a, 8'h01, 8'h91, acks);
    chk({n_front[3:0], n_core[3:0]}, 8'h11);
    chk(auto_sleep, 1'b1);
    scfg_host_model_i.reg_write(7'h1a, 8'h01, 8'h02, acks);
    chk({cable, auto_sleep}, 2'h0);
  endtask

  task automatic t_override();
    logic [2:0] acks;
    logic ack;
    scfg_host_model_i.reg_write(7'h1a, 8'h00, 8'h61, acks);
    scfg_host_model_i.probe(7'h30, 1'b1, ack);
    chk(ack, 1'b1);
    scfg_host_model_i.probe(7'h1a, 1'b1, ack);
    chk(ack, 1'b0);
  endtask

  initial begin
    do_reset();
    t_pixel();
    t_strap();
    strap_a = 3'h0;
    strap_b = 3'h0;
    t_addr();
    t_regs();
    t_override();
    results();
  end

  // the full sequence needs roughly 82k cycles
  initial begin
    repeat (98000) @(posedge ref_clk);
    n_fail++;
    results();
  end
endmodule
